// [src/usr_ctrl.sv]
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "usr_cfg.svh"
// What this block does
// - While suspended and resume bit set, drive resume signalling; stop when cleared.
// - Suspended status reads 1 in suspend; host may set it, hardware clears it on resume in the peripheral role.
// - Suspend entered only while suspend enable is 1.
// - Peripheral role uses the 7-bit function address to decode tokens.
// - General event flag set on any bus event; read-only, cleared by writing 1 to the clear register.
// - Resume flag set on resume seen during suspend; else reads 0.
// - Activity flag set on connect, disconnect or activity; resets to 1.
// - ID override enable selects override value, else the PHY ID.
// - ID override value gives the ID level used under override.
// - PHY ID monitored only while ID monitor enable is 1.
// - Bus-valid monitored only while its monitor enable is 1.
// - A-side session valid monitored only while its enable is 1.
// - B-side session valid monitored only while its enable is 1.
// - Clock/reset control bit 15 reads 1; unused bits read 0.
module usr_ctrl
(
	// Clock and reset
	input  wire logic             CLK,
	input  wire logic             RESETN,
	// APB slave
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [11:0]      PADDR,
	input  wire logic [31:0]      PWDATA,
	input  wire logic [3:0]       PSTRB,
	output logic                  PREADY,
	output logic                  PSLVERR,
	output logic [31:0]           PRDATA,
	// PHY indications, asynchronous
	input  wire usr_pkg::usr_phy_t PHY,
	// Protocol core, same clock
	input  wire usr_pkg::usr_core_t CORE,
	// Outputs to core and PHY
	output logic                  RESUME_DRIVE,
	output logic                  SUSPENDED,
	output logic [6:0]            FUNC_ADDR,
	output logic                  CABLE_ID,
	output logic                  BUS_VALID,
	output logic                  A_SESSION,
	output logic                  B_SESSION,
	output logic                  SESSION_END,
	output logic                  IRQ
);
	usr_pkg::usr_state_t s_r;
	usr_pkg::usr_state_t s_nxt;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction : hit

	logic        wr;
	logic        rd;
	logic [4:0]  agree;
	logic [2:0]  ev_set;
	logic [31:0] cr_word;
	assign wr = PSEL && PENABLE && PWRITE && s_r.pready;
	assign rd = PSEL && !PENABLE && !PWRITE;

	// ----------------------------------------
	// Three-stage sync of all PHY levels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_agree
			assign agree[g] = (s_r.syn2[g] == s_r.syn3[g]);
		end
	endgenerate

	always_comb
	begin
		cr_word = 32'h0000_0000;
		cr_word[`USR_CR_GEN]     = s_r.ev[2];
		cr_word[`USR_CR_RES]     = s_r.ev[1];
		cr_word[`USR_CR_ACT]     = s_r.ev[0];
		cr_word[`USR_CR_RSVD]    = 1'b1;
		cr_word[`USR_CR_IDOVEN]  = s_r.id_override_enable;
		cr_word[`USR_CR_IDVAL]   = s_r.id_override_value;
		cr_word[`USR_CR_IDMON:`USR_CR_SEMON] = s_r.mon_en;
		cr_word[`USR_CR_GENIE:`USR_CR_ACTIE] = s_r.ie;
	end

	always_comb
	begin
		s_nxt = s_r;
		ev_set = 3'h0;
		// Every PHY level is asynchronous, so all five are filtered
		s_nxt.syn1 = PHY;
		s_nxt.syn2 = s_r.syn1;
		s_nxt.syn3 = s_r.syn2;
		for (int i = 0; i < 5; i++)
		begin
			if (agree[i])
			begin
				s_nxt.prev[i] = s_r.syn3[i];
			end
		end
		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (wr && hit(PADDR, `USR_OFF_CSR0))
		begin
			if (PSTRB[1])
			begin
				s_nxt.resume         = PWDATA[`USR_CSR0_RESUME];
				s_nxt.suspend_enable = PWDATA[`USR_CSR0_SUSPEND_ENABLE];
				if (CORE.host_mode && PWDATA[`USR_CSR0_SUSP] && PWDATA[`USR_CSR0_SUSPEND_ENABLE])
				begin
					s_nxt.suspended = 1'b1;
				end
			end
			if (PSTRB[0])
			begin
				s_nxt.function_address = PWDATA[`USR_CSR0_FADDR_H:0];
			end
		end
		if (wr && hit(PADDR, `USR_OFF_CRCON))
		begin
			if (PSTRB[1])
			begin
				s_nxt.id_override_enable = PWDATA[`USR_CR_IDOVEN];
				s_nxt.id_override_value  = PWDATA[`USR_CR_IDVAL];
			end
			if (PSTRB[0])
			begin
				s_nxt.mon_en = PWDATA[`USR_CR_IDMON:`USR_CR_SEMON];
				s_nxt.ie     = PWDATA[`USR_CR_GENIE:`USR_CR_ACTIE];
			end
		end
		if (wr && hit(PADDR, `USR_OFF_EVEN) && PSTRB[0])
		begin
			s_nxt.ie = PWDATA[2:0];
		end
		// Activity flag also clears from its control bit; the others by clear register
		if (wr && hit(PADDR, `USR_OFF_CRCON) && PSTRB[3] && !PWDATA[`USR_CR_ACT])
		begin
			s_nxt.ev[0] = 1'b0;
		end
		if (wr && hit(PADDR, `USR_OFF_EVCLR) && PSTRB[0])
		begin
			s_nxt.ev = s_nxt.ev & ~PWDATA[2:0];
		end
		// ----------------------------------------
		// Suspend and resume
		// ----------------------------------------
		if (CORE.suspend_cond && s_r.suspend_enable)
		begin
			s_nxt.suspended = 1'b1;
		end
		if (!s_nxt.suspend_enable || (s_r.suspended && CORE.resume_seen && !CORE.host_mode))
		begin
			s_nxt.suspended = 1'b0;
		end
		if (!s_r.suspended)
		begin
			s_nxt.ev[1] = 1'b0;
		end
		s_nxt.resume_drive = s_r.suspended && s_r.resume;
		// ----------------------------------------
		// Events: set wins over clear
		// ----------------------------------------
		ev_set[2] = CORE.bus_event;
		ev_set[1] = CORE.resume_seen && s_r.suspended;
		ev_set[0] = CORE.bus_activity || (s_r.prev[3] != s_r.syn3[3] && agree[3]);
		s_nxt.ev = s_nxt.ev | ev_set;
		s_nxt.irq = |(s_r.ev & s_r.ie);
		// ----------------------------------------
		// ID and VBUS monitoring
		// ----------------------------------------
		if (s_r.id_override_enable)
		begin
			s_nxt.cable_id = s_r.id_override_value;
		end
		else if (s_r.mon_en[4] && agree[4])
		begin
			s_nxt.cable_id = s_r.syn3[4];
		end
		s_nxt.bus_valid   = s_r.mon_en[3] && s_r.prev[3];
		s_nxt.a_session   = s_r.mon_en[2] && s_r.prev[2];
		s_nxt.b_session   = s_r.mon_en[1] && s_r.prev[1];
		s_nxt.session_end = s_r.mon_en[0] && s_r.prev[0];
		// Registered so a role change reaches the core without a glitch
		s_nxt.func_addr_out = CORE.host_mode ? 7'h00 : s_nxt.function_address;
		// ----------------------------------------
		// APB answer: zero wait state
		// ----------------------------------------
		s_nxt.pready  = PSEL && !PENABLE;
		s_nxt.pslverr = PSEL && !PENABLE && !(hit(PADDR, `USR_OFF_CSR0) || hit(PADDR, `USR_OFF_CRCON)
			|| hit(PADDR, `USR_OFF_EVSTAT) || hit(PADDR, `USR_OFF_EVCLR) || hit(PADDR, `USR_OFF_EVEN));
		s_nxt.prdata  = 32'h0000_0000;
		if (rd)
		begin
			if (hit(PADDR, `USR_OFF_CSR0))
			begin
				s_nxt.prdata[`USR_CSR0_RESUME] = s_r.resume;
				s_nxt.prdata[`USR_CSR0_SUSP]   = s_r.suspended;
				s_nxt.prdata[`USR_CSR0_SUSPEND_ENABLE] = s_r.suspend_enable;
				s_nxt.prdata[`USR_CSR0_FADDR_H:0] = s_r.function_address;
			end
			else if (hit(PADDR, `USR_OFF_CRCON))
			begin
				s_nxt.prdata = cr_word;
			end
			else if (hit(PADDR, `USR_OFF_EVSTAT))
			begin
				s_nxt.prdata[2:0] = s_r.ev;
			end
			else if (hit(PADDR, `USR_OFF_EVEN))
			begin
				s_nxt.prdata[2:0] = s_r.ie;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			s_r    <= '0;
			s_r.ev <= `USR_RST_EVENTS;
			s_r.ie <= `USR_RST_IE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PREADY       = s_r.pready;
	assign PSLVERR      = s_r.pslverr;
	assign PRDATA       = s_r.prdata;
	assign RESUME_DRIVE = s_r.resume_drive;
	assign SUSPENDED    = s_r.suspended;
	assign FUNC_ADDR    = s_r.func_addr_out;
	assign CABLE_ID     = s_r.cable_id;
	assign BUS_VALID    = s_r.bus_valid;
	assign A_SESSION    = s_r.a_session;
	assign B_SESSION    = s_r.b_session;
	assign SESSION_END  = s_r.session_end;
	assign IRQ          = s_r.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_resume_req;
		s_r.suspended && s_r.resume;
	endsequence

	AST_RESUME_DRIVE: assert property (@(posedge CLK) disable iff (!RESETN)
		seq_resume_req |=> RESUME_DRIVE)
		else $error("resume not driven");
	AST_RESUME_STOP: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.resume |=> !RESUME_DRIVE)
		else $error("resume still driven");
	AST_SUSP_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(SUSPENDED) |-> $past(s_r.suspend_enable))
		else $error("suspend without enable");
	AST_GEN_SET: assert property (@(posedge CLK) disable iff (!RESETN)
		CORE.bus_event |=> s_r.ev[2])
		else $error("general flag missed");
	AST_RES_ZERO: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.suspended && !CORE.resume_seen ##1 !s_r.suspended |-> !s_r.ev[1])
		else $error("resume flag outside suspend");
	AST_ACT_SET: assert property (@(posedge CLK) disable iff (!RESETN)
		CORE.bus_activity |=> s_r.ev[0])
		else $error("activity flag missed");
	AST_ID_OVR: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.id_override_enable |=> CABLE_ID == $past(s_r.id_override_value))
		else $error("override id not used");
	AST_VBUS_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.mon_en[3] |=> !BUS_VALID)
		else $error("bus valid not gated");
	AST_IRQ: assert property (@(posedge CLK) disable iff (!RESETN)
		IRQ |-> $past(|(s_r.ev & s_r.ie)))
		else $error("irq without enabled flag");

	// ----------------------------------------
	// Checks on ID and supply monitoring
	// ----------------------------------------
	// An unmonitored ID keeps its last level, so CABLE_ID may carry a stale value
	sequence seq_id_from_phy;
		!s_r.id_override_enable && s_r.mon_en[4] && agree[4];
	endsequence

	sequence seq_id_frozen;
		!s_r.id_override_enable && !s_r.mon_en[4];
	endsequence

	AST_ID_PHY: assert property (@(posedge CLK) disable iff (!RESETN)
		seq_id_from_phy |=> CABLE_ID == $past(s_r.syn3[4]))
		else $error("phy id not followed");
	AST_ID_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
		seq_id_frozen |=> $stable(CABLE_ID))
		else $error("id moved while unmonitored");
	AST_ID_LOW: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.id_override_enable && !s_r.id_override_value |=> !CABLE_ID)
		else $error("override low not used");

	AST_VBUS_PASS: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.mon_en[3] |=> BUS_VALID == $past(s_r.prev[3]))
		else $error("bus valid not followed");
	AST_ASESS_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.mon_en[2] |=> !A_SESSION)
		else $error("a session not gated");
	AST_ASESS_PASS: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.mon_en[2] |=> A_SESSION == $past(s_r.prev[2]))
		else $error("a session not followed");
	AST_BSESS_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.mon_en[1] |=> !B_SESSION)
		else $error("b session not gated");
	AST_BSESS_PASS: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.mon_en[1] |=> B_SESSION == $past(s_r.prev[1]))
		else $error("b session not followed");
	AST_SEND_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.mon_en[0] |=> !SESSION_END)
		else $error("session end not gated");

	// ----------------------------------------
	// Checks on suspend, events and bus
	// ----------------------------------------
	sequence seq_awake_idle;
		!s_r.suspended && !CORE.host_mode && !(CORE.suspend_cond && s_r.suspend_enable);
	endsequence

	AST_RESUME_IDLE: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.suspended |=> !RESUME_DRIVE)
		else $error("resume driven while awake");
	AST_SUSP_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
		seq_awake_idle |=> !SUSPENDED)
		else $error("suspend without cause");
	AST_SUSP_DROP: assert property (@(posedge CLK) disable iff (!RESETN)
		!s_r.suspend_enable && !(wr && hit(PADDR, `USR_OFF_CSR0) && PSTRB[1]) |=> !SUSPENDED)
		else $error("suspended while disabled");
	AST_FADDR_HOST: assert property (@(posedge CLK) disable iff (!RESETN)
		CORE.host_mode |=> FUNC_ADDR == 7'h00)
		else $error("address used in host role");

	AST_GEN_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.ev[2] && !(wr && hit(PADDR, `USR_OFF_EVCLR) && PSTRB[0] && PWDATA[2]) |=> s_r.ev[2])
		else $error("general flag lost");
	AST_RES_SET: assert property (@(posedge CLK) disable iff (!RESETN)
		s_r.suspended && CORE.resume_seen |=> s_r.ev[1])
		else $error("resume flag missed");
	AST_ACT_EDGE: assert property (@(posedge CLK) disable iff (!RESETN)
		agree[3] && s_r.prev[3] != s_r.syn3[3] |=> s_r.ev[0])
		else $error("supply change not flagged");
	AST_IRQ_SET: assert property (@(posedge CLK) disable iff (!RESETN)
		|(s_r.ev & s_r.ie) |=> IRQ)
		else $error("enabled flag without irq");
	AST_IRQ_LOW: assert property (@(posedge CLK) disable iff (!RESETN)
		!(|(s_r.ev & s_r.ie)) |=> !IRQ)
		else $error("irq while quiet");

	AST_RSVD: assert property (@(posedge CLK) disable iff (!RESETN)
		rd && hit(PADDR, `USR_OFF_CRCON) |=> PRDATA[`USR_CR_RSVD])
		else $error("reserved bit not one");
	AST_PREADY: assert property (@(posedge CLK) disable iff (!RESETN)
		PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	AST_PRDATA_IDLE: assert property (@(posedge CLK) disable iff (!RESETN)
		!rd |=> PRDATA == 32'h0000_0000)
		else $error("read data outside access");
endmodule : usr_ctrl

// [src/usr_cfg.svh]
`ifndef USR_CFG_SVH
`define USR_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define USR_OFF_CSR0     12'h000
`define USR_OFF_CRCON    12'h004
`define USR_OFF_EVSTAT   12'h008
`define USR_OFF_EVCLR    12'h00C
`define USR_OFF_EVEN     12'h010
// ----------------------------------------
// Control status 0 fields
// ----------------------------------------
`define USR_CSR0_RESUME  10
`define USR_CSR0_SUSP    9
`define USR_CSR0_SUSPEND_ENABLE  8
`define USR_CSR0_FADDR_H 6
// ----------------------------------------
// Clock/reset control fields
// ----------------------------------------
`define USR_CR_GEN       26
`define USR_CR_RES       25
`define USR_CR_ACT       24
`define USR_CR_RSVD      15
`define USR_CR_IDOVEN    9
`define USR_CR_IDVAL     8
`define USR_CR_IDMON     7
`define USR_CR_VBMON     6
`define USR_CR_ASMON     5
`define USR_CR_BSMON     4
`define USR_CR_SEMON     3
`define USR_CR_GENIE     2
`define USR_CR_RESIE     1
`define USR_CR_ACTIE     0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define USR_RST_EVENTS   3'h1
`define USR_RST_IE       3'h0
`endif

// [src/usr_pkg.sv]
package usr_pkg;
	typedef struct packed {
		logic       id;
		logic       vbus_valid;
		logic       a_sess;
		logic       b_sess;
		logic       sess_end;
	} usr_phy_t;

	typedef struct packed {
		logic       host_mode;
		logic       bus_event;
		logic       resume_seen;
		logic       bus_activity;
		logic       suspend_cond;
	} usr_core_t;

	typedef struct packed {
		logic       resume;
		logic       suspended;
		logic       suspend_enable;
		logic [6:0] function_address;
		logic       id_override_enable;
		logic       id_override_value;
		logic [4:0] mon_en;
		logic [2:0] ev;
		logic [2:0] ie;
		logic [4:0] syn1;
		logic [4:0] syn2;
		logic [4:0] syn3;
		logic [4:0] prev;
		logic [6:0] func_addr_out;
		logic       cable_id;
		logic       bus_valid;
		logic       a_session;
		logic       b_session;
		logic       session_end;
		logic       resume_drive;
		logic       irq;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} usr_state_t;
endpackage : usr_pkg

// [verif/usr_far.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far side: PHY levels and core events
// ----------------------------------------
module usr_far
(
	// Clock
	input  wire logic               CLK,
	// Towards the block
	output usr_pkg::usr_core_t      CORE,
	output usr_pkg::usr_phy_t       PHY
);
	initial
	begin
		CORE = '0;
		PHY  = '0;
	end
	// One-cycle pulses: bus_event, resume_seen, bus_activity, suspend_cond
	task pulse(input logic [3:0] ev);
		@(posedge CLK);
		CORE[3:0] <= ev;
		@(posedge CLK);
		CORE[3:0] <= 4'h0;
	endtask : pulse
	task host(input logic h);
		@(posedge CLK);
		CORE.host_mode <= h;
	endtask : host
	// Levels change off any bus activity, as a cable would
	task phy(input usr_pkg::usr_phy_t v);
		@(posedge CLK);
		PHY <= v;
	endtask : phy
endmodule : usr_far

// [verif/tb.sv]
`timescale 1ns/1ps
`include "usr_cfg.svh"
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic               CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic               RESUME_DRIVE, SUSPENDED, CABLE_ID, BUS_VALID, A_SESSION, B_SESSION, SESSION_END, IRQ;
	logic [11:0]        PADDR;
	logic [31:0]        PWDATA, PRDATA, rd, seed;
	logic [3:0]         PSTRB;
	logic [6:0]         FUNC_ADDR, fa;
	logic [6:0]         c;
	logic [4:0]         em;
	usr_pkg::usr_phy_t  PHY;
	usr_pkg::usr_core_t CORE;
	int                 n_fail, compares;

	usr_ctrl i_usr_ctrl (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
		.PHY(PHY), .CORE(CORE), .RESUME_DRIVE(RESUME_DRIVE), .SUSPENDED(SUSPENDED), .FUNC_ADDR(FUNC_ADDR),
		.CABLE_ID(CABLE_ID), .BUS_VALID(BUS_VALID), .A_SESSION(A_SESSION), .B_SESSION(B_SESSION),
		.SESSION_END(SESSION_END), .IRQ(IRQ));
	usr_far i_usr_far (.CLK(CLK), .CORE(CORE), .PHY(PHY));

	initial
	begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// {cable id, bus valid, a session, b session, session end}; unmonitored id keeps its level
	function logic [4:0] exp_mon(input logic [6:0] k, input usr_pkg::usr_phy_t p, input logic held);
		return {k[6] ? k[5] : (k[4] ? p.id : held), k[3] & p.vbus_valid, k[2] & p.a_sess, k[1] & p.b_sess,
			k[0] & p.sess_end};
	endfunction : exp_mon
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Waits on PREADY, never on a fixed count
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 20);
		if (n >= 20)
			n_fail++;
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task settle;
		repeat (3) @(posedge CLK);
	endtask : settle
	task tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge CLK);
		n_fail++;
		tally_and_finish;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		PSTRB = 4'hf;
		RESETN = 1'b0;
		seed = 32'hdd81_5a9c;
		em = 5'h00;
		n_fail = 0;
		compares = 0;
		repeat (10) @(posedge CLK);
		RESETN <= 1'b1;
		apb(1'b0, `USR_OFF_CRCON, 32'h0000_0000);
		chk(rd, 32'h0100_8000);
		apb(1'b0, `USR_OFF_CSR0, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 12'h0ff, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		apb(1'b1, `USR_OFF_EVCLR, 32'h0000_0007);
		apb(1'b0, `USR_OFF_EVSTAT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		i_usr_far.pulse(4'b0010);
		apb(1'b0, `USR_OFF_EVSTAT, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		i_usr_far.pulse(4'b1000);
		apb(1'b0, `USR_OFF_EVSTAT, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		// Resume flag must stay low while awake
		i_usr_far.pulse(4'b0100);
		apb(1'b0, `USR_OFF_EVSTAT, 32'h0000_0000);
		chk(rd[1], 1'b0);
		// Flags 101: the resume enable alone must stay quiet
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, `USR_OFF_EVEN, 32'h0000_0001 << i);
			settle;
			chk(IRQ, i != 1);
		end
		apb(1'b1, `USR_OFF_EVCLR, 32'h0000_0007);
		apb(1'b1, `USR_OFF_EVEN, 32'h0000_0007);
		settle;
		chk(IRQ, 1'b0);
		// Activity flag cleared through its own lane only
		i_usr_far.pulse(4'b0010);
		settle;
		chk(IRQ, 1'b1);
		PSTRB <= 4'h8;
		apb(1'b1, `USR_OFF_CRCON, 32'h0000_0000);
		PSTRB <= 4'hf;
		apb(1'b0, `USR_OFF_EVSTAT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		settle;
		chk(IRQ, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			fa = (k == 0) ? 7'h7f : seed[6:0];
			apb(1'b1, `USR_OFF_CSR0, {25'h0, fa});
			apb(1'b0, `USR_OFF_CSR0, 32'h0000_0000);
			chk(rd, {25'h0, fa});
			chk(FUNC_ADDR, fa);
		end
		i_usr_far.host(1'b1);
		settle;
		chk(FUNC_ADDR, 7'h00);
		i_usr_far.host(1'b0);
		apb(1'b1, `USR_OFF_CSR0, 32'h0000_0000);
		i_usr_far.pulse(4'b0001);
		settle;
		chk(SUSPENDED, 1'b0);
		apb(1'b1, `USR_OFF_CSR0, 32'h0000_0100);
		i_usr_far.pulse(4'b0001);
		apb(1'b0, `USR_OFF_CSR0, 32'h0000_0000);
		chk(rd, 32'h0000_0300);
		chk(SUSPENDED, 1'b1);
		// Lane 0 alone moves the address and leaves suspend control alone
		PSTRB <= 4'h1;
		apb(1'b1, `USR_OFF_CSR0, 32'h0000_0055);
		PSTRB <= 4'hf;
		apb(1'b0, `USR_OFF_CSR0, 32'h0000_0000);
		chk(rd, 32'h0000_0355);
		apb(1'b1, `USR_OFF_CSR0, 32'h0000_0500);
		settle;
		chk(RESUME_DRIVE, 1'b1);
		// Software ends resume signalling; the long wait is scaled away
		apb(1'b1, `USR_OFF_CSR0, 32'h0000_0100);
		settle;
		chk(RESUME_DRIVE, 1'b0);
		// PHY levels cross three flops, so wait past them
		for (int k = 0; k < 8; k++)
		begin
			seed = lfsr(seed);
			c = {k[1:0], seed[13:9]};
			i_usr_far.phy(usr_pkg::usr_phy_t'(seed[4:0]));
			apb(1'b1, `USR_OFF_CRCON, {22'h0, c, 3'h0});
			repeat (6) @(posedge CLK);
			em = exp_mon(c, seed[4:0], em[4]);
			chk({CABLE_ID, BUS_VALID, A_SESSION, B_SESSION, SESSION_END}, em);
		end
		tally_and_finish;
	end
endmodule : tb
